// File: rtl/fsp_status_reg.sv
// Purpose: status register with block protection, latch and busy flag
// Assumes: host commands arrive as one-cycle decoded strobes on clock_i
// Notes: program/erase/write time is a fixed count of busy cycles
`timescale 1ns/100ps
module fsp_status_reg
    import fsp_pkg::*;
#(
    parameter int BUSY_CYC = FSP_BUSY_CYC
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // protect pin, from outside the clock domain
    input wire logic write_protect_n_i,
    // decoded host commands
    input wire logic write_enable_cmd_i,
    input wire logic write_disable_cmd_i,
    input wire logic write_status_cmd_i,
    input wire logic [7:0] write_status_data_i,
    input wire logic array_op_cmd_i,
    input wire fsp_pkg::fsp_op_type array_op_i,
    input wire logic [FSP_ADDR_W-1:0] array_addr_i,
    input wire logic clear_flags_cmd_i,
    // register views
    output logic [7:0] status_o,
    output logic [7:0] flag_status_o,
    // array engine
    output logic op_start_o,
    output logic op_reject_o
);
    import fsp_pkg::*;

    typedef enum logic [1:0] {FSP_IDLE, FSP_BUSY} fsp_state_type;

    logic [2:0] wp_sync_ff;
    logic wp_level_ff;
    logic [7:0] nv_ff, nxt_nv;
    logic wel_ff, nxt_wel;
    fsp_state_type state_ff, nxt_state;
    logic [FSP_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic perr_ff, nxt_perr;
    logic eerr_ff, nxt_eerr;
    logic prerr_ff, nxt_prerr;
    logic [7:0] status_ff, nxt_status;
    logic [7:0] fsr_ff, nxt_fsr;
    logic start_ff, nxt_start;
    logic rej_ff, nxt_rej;
    logic hw_locked;
    logic [3:0] bp;
    logic blocked;

    // true when the sector holding addr lies in the protected region
    function automatic logic fsp_is_protected(input logic [3:0] bpv, input logic tb,
                                              input logic [FSP_ADDR_W-1:0] addr);
        logic [FSP_SECT_W-1:0] sect;
        logic [FSP_SECT_W:0] span;
        sect = addr[FSP_ADDR_W-1:FSP_SECT_LSB]; // [R12]
        span = '0;
        if (bpv == 4'h0) begin
            return 1'b0; // [R13]
        end
        if (bpv >= FSP_BP_ALL) begin
            return 1'b1; // [R13]
        end
        span = (FSP_SECT_W+1)'(1) << (bpv - 4'h1); // [R13]
        if (tb) begin
            return {1'b0, sect} < span; // [R5]
        end
        return {1'b0, ~sect} < span; // [R5]
    endfunction

    // pin passes three flops; a change counts once stages two and three agree
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wp_sync_ff <= 3'h0;
            wp_level_ff <= 1'b0;
        end else begin
            wp_sync_ff <= {wp_sync_ff[1:0], write_protect_n_i};
            if (wp_sync_ff[2] == wp_sync_ff[1]) begin
                wp_level_ff <= wp_sync_ff[2];
            end
        end
    end

    assign bp = {nv_ff[FSP_BIT_BP3], nv_ff[FSP_BIT_BP_HI:FSP_BIT_BP_LO]};
    // only a high pin releases it; no command touches the pin level
    assign hw_locked = nv_ff[FSP_BIT_LOCK] & ~wp_level_ff; // [R2] [R3] [R4]

    always_comb begin
        nxt_nv = nv_ff;
        nxt_wel = wel_ff;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_perr = perr_ff;
        nxt_eerr = eerr_ff;
        nxt_prerr = prerr_ff;
        nxt_start = 1'b0;
        nxt_rej = 1'b0;
        blocked = 1'b0;
        if (clear_flags_cmd_i) begin
            nxt_perr = 1'b0;
            nxt_eerr = 1'b0;
            nxt_prerr = 1'b0;
        end
        unique case (state_ff)
            FSP_IDLE: begin
                if (write_enable_cmd_i) begin
                    nxt_wel = 1'b1; // [R8]
                end else if (write_disable_cmd_i) begin
                    nxt_wel = 1'b0;
                end else if (write_status_cmd_i && wel_ff) begin
                    if (hw_locked) begin
                        nxt_wel = 1'b0; // [R2] [R15]
                        nxt_rej = 1'b1;
                    end else begin
                        // bits 1:0 are not writable
                        nxt_nv = write_status_data_i & FSP_NV_MASK; // [R1] [R4]
                        nxt_state = FSP_BUSY;
                        nxt_cnt = FSP_CNT_W'(BUSY_CYC - 1);
                    end
                end else if (array_op_cmd_i && wel_ff) begin // [R8]
                    if (array_op_i == FSP_OP_DIE_ERASE) begin
                        blocked = (bp != 4'h0); // [R11]
                    end else begin
                        blocked = fsp_is_protected(bp, nv_ff[FSP_BIT_TB], array_addr_i); // [R6]
                    end
                    if (blocked) begin
                        nxt_perr = 1'b1; // [R14]
                        if (array_op_i == FSP_OP_PROG) begin
                            nxt_prerr = 1'b1;
                        end else begin
                            nxt_eerr = 1'b1;
                        end
                        nxt_wel = 1'b0; // [R15]
                        nxt_rej = 1'b1;
                    end else begin
                        nxt_start = 1'b1;
                        nxt_state = FSP_BUSY;
                        nxt_cnt = FSP_CNT_W'(BUSY_CYC - 1);
                    end
                end
            end
            FSP_BUSY: begin
                // commands other than flag clear are ignored while busy
                if (cnt_ff == '0) begin
                    nxt_state = FSP_IDLE;
                    nxt_wel = 1'b0; // [R15]
                end else begin
                    nxt_cnt = cnt_ff - FSP_CNT_W'(1);
                end
            end
            default: begin
                nxt_state = FSP_IDLE;
            end
        endcase
        nxt_status = nxt_nv & FSP_NV_MASK;
        nxt_status[FSP_BIT_WEL] = nxt_wel;
        nxt_status[FSP_BIT_BUSY] = (nxt_state == FSP_BUSY); // [R9]
        nxt_fsr = 8'h00;
        nxt_fsr[FSP_FSR_READY] = ~nxt_status[FSP_BIT_BUSY]; // [R10]
        nxt_fsr[FSP_FSR_ERASE_ERR] = nxt_eerr;
        nxt_fsr[FSP_FSR_PROG_ERR] = nxt_prerr;
        nxt_fsr[FSP_FSR_PROT_ERR] = nxt_perr;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            nv_ff <= FSP_NV_RESET;
            wel_ff <= 1'b0; // [R7]
            state_ff <= FSP_IDLE;
            cnt_ff <= '0;
            perr_ff <= 1'b0;
            eerr_ff <= 1'b0;
            prerr_ff <= 1'b0;
            status_ff <= 8'h00;
            fsr_ff <= 8'h80;
            start_ff <= 1'b0;
            rej_ff <= 1'b0;
        end else begin
            nv_ff <= nxt_nv;
            wel_ff <= nxt_wel;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            perr_ff <= nxt_perr;
            eerr_ff <= nxt_eerr;
            prerr_ff <= nxt_prerr;
            status_ff <= nxt_status;
            fsr_ff <= nxt_fsr;
            start_ff <= nxt_start;
            rej_ff <= nxt_rej;
        end
    end

    assign status_o = status_ff; // [R1]
    assign flag_status_o = fsr_ff;
    assign op_start_o = start_ff;
    assign op_reject_o = rej_ff;
endmodule

// File: pkg/fsp_pkg.sv
// What this block does
// (R1) read-status returns register, write-status updates writable bits
// (R2) lock bit 7 with protect pin low blocks writes
// (R3) only a high protect pin releases hardware protection
// (R4) lock bit nonvolatile, zero permits status writes
// (R5) bit 5 anchors region top or bottom
// (R6) block protect bits 6,4:2 refuse protected operations
// (R7) write-enable latch bit 1 clears at power-up
// (R8) operations run only while write-enable latch set
// (R9) bit 0 busy during write, program, erase
// (R10) busy equals inverse of flag ready bit
// (R11) die erase only when all protect bits zero
// (R12) linear map of 4096 sectors, subsectors
// (R13) protected size doubles per value, 13-15 all
// (R14) protected attempt sets protection error flag
// (R15) latch clears on completion or rejection
//
// Purpose: constants for the status and block-protect register logic
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes: nonvolatile bits are modelled as flip-flops loaded by reset defaults
package fsp_pkg;
    localparam int FSP_ADDR_W = 28;
    localparam int FSP_SECT_W = 12;
    localparam int FSP_SECT_LSB = 16;
    localparam logic [FSP_ADDR_W-1:0] FSP_TOP_ADDR = 28'hfffffff;
    localparam int FSP_BIT_LOCK = 7;
    localparam int FSP_BIT_BP3 = 6;
    localparam int FSP_BIT_TB = 5;
    localparam int FSP_BIT_BP_HI = 4;
    localparam int FSP_BIT_BP_LO = 2;
    localparam int FSP_BIT_WEL = 1;
    localparam int FSP_BIT_BUSY = 0;
    localparam logic [7:0] FSP_NV_MASK = 8'hfc;
    localparam logic [7:0] FSP_NV_RESET = 8'h00;
    localparam logic [3:0] FSP_BP_ALL = 4'hd;
    localparam int FSP_FSR_READY = 7;
    localparam int FSP_FSR_ERASE_ERR = 5;
    localparam int FSP_FSR_PROG_ERR = 4;
    localparam int FSP_FSR_PROT_ERR = 1;
    localparam int FSP_BUSY_CYC = 8;
    localparam int FSP_CNT_W = 4;
    typedef enum logic [1:0] {
        FSP_OP_PROG,
        FSP_OP_SECT_ERASE,
        FSP_OP_DIE_ERASE
    } fsp_op_type;
endpackage

// File: test/fsp_status_reg_props.sv
// Purpose: port checks for fsp_status_reg
// Assumes: one clock, sync reset
// Notes: pin held low 5 cycles covers the synchroniser
`timescale 1ns/100ps
module fsp_status_reg_props
    import fsp_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // inputs
    input wire logic write_protect_n_i,
    input wire logic write_status_cmd_i,
    input wire logic array_op_cmd_i,
    input wire fsp_pkg::fsp_op_type array_op_i,
    // outputs
    input wire logic [7:0] status_o,
    input wire logic [7:0] flag_status_o,
    input wire logic op_start_o,
    input wire logic op_reject_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    busy_ready_a: assert property (status_o[0] == !flag_status_o[7])
        else $error("busy vs ready");
    reset_view_a: assert property ($past(reset_i) |-> status_o == 8'h00)
        else $error("reset view");
    start_busy_a: assert property (op_start_o |-> status_o[0])
        else $error("start not busy");
    busy_latch_a: assert property ($rose(status_o[0]) |-> $past(status_o[1]))
        else $error("busy without latch");
    reject_clear_a: assert property (op_reject_o |-> !status_o[1] && $past(status_o[1]))
        else $error("reject latch");
    done_clear_a: assert property ($fell(status_o[0]) |-> !status_o[1])
        else $error("done latch");
    one_answer_a: assert property (!(op_start_o && op_reject_o))
        else $error("start and reject");
    die_guard_a: assert property (array_op_cmd_i && array_op_i == FSP_OP_DIE_ERASE &&
        (status_o[6] || status_o[4:2] != 3'h0) |=> !op_start_o) else $error("die erase");
    lock_hold_a: assert property (!write_protect_n_i [*5] ##0
        (write_status_cmd_i && status_o[7]) |=> $stable(status_o[7:2])) else $error("lock");
endmodule
bind fsp_status_reg fsp_status_reg_props i_props(.clock_i, .reset_i, .write_protect_n_i,
    .write_status_cmd_i, .array_op_cmd_i, .array_op_i, .status_o, .flag_status_o,
    .op_start_o, .op_reject_o);

// File: test/fsp_host.sv
// Purpose: host issuing decoded flash commands
// Assumes: inputs change 1 ns after the rising edge
// Notes: cmd_o is enable, disable, write, op, clear
`timescale 1ns/100ps
module fsp_host
    import fsp_pkg::*;
(
    // clock
    input wire logic clock_i,
    // commands
    output logic protect_n_o,
    output logic [4:0] cmd_o,
    output logic [7:0] data_o,
    output fsp_pkg::fsp_op_type op_o,
    output logic [FSP_ADDR_W-1:0] addr_o
);
    initial begin
        protect_n_o = 1'b0;
        cmd_o = 5'h00;
        {data_o, addr_o} = 36'h0;
        op_o = FSP_OP_PROG;
    end
    // one-cycle strobe; no enable is sent ahead of an op
    task automatic send(input int k, input logic [7:0] d, input fsp_op_type t,
        input logic [FSP_ADDR_W-1:0] a);
        @(posedge clock_i) #1;
        cmd_o = 5'h10 >> k;
        data_o = d;
        op_o = t;
        addr_o = a;
        @(posedge clock_i) #1;
        cmd_o = 5'h00;
    endtask
    // only a high pin lifts the lock
    task automatic pin(input logic v);
        @(posedge clock_i) #1;
        protect_n_o = v;
    endtask
endmodule

// File: test/fsp_status_reg_test.sv
// Purpose: self-checking bench for fsp_status_reg
// Assumes: busy count shortened to 4
// Notes: monitor pops one note per start or reject pulse
`timescale 1ns/100ps
module fsp_status_reg_test;
    import fsp_pkg::*;
    logic clock_i = 1'b0, reset_i = 1'b1, wp, op_start_o, op_reject_o;
    logic [4:0] cmd;
    logic [7:0] wd, status_o, flag_status_o;
    logic [27:0] aa;
    fsp_op_type ak;
    int mismatches = 0, comparisons = 0, sect;
    logic q[$];
    always #20 clock_i = ~clock_i;
    fsp_host i_fsp_host(.clock_i, .protect_n_o(wp), .cmd_o(cmd), .data_o(wd), .op_o(ak),
        .addr_o(aa));
    fsp_status_reg #(.BUSY_CYC(4)) i_fsp_status_reg(.clock_i, .reset_i,
        .write_protect_n_i(wp), .write_enable_cmd_i(cmd[4]), .write_disable_cmd_i(cmd[3]),
        .write_status_cmd_i(cmd[2]), .write_status_data_i(wd), .array_op_cmd_i(cmd[1]),
        .array_op_i(ak), .array_addr_i(aa), .clear_flags_cmd_i(cmd[0]), .status_o,
        .flag_status_o, .op_start_o, .op_reject_o);
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // pulses launch on the rising edge, so look on the falling one to avoid a race
    always @(negedge clock_i) begin
        if (!reset_i && (op_start_o || op_reject_o)) begin
            if (q.size() == 0) chk(8'h01, 8'h00);
            else chk({7'h0, op_start_o}, {7'h0, q.pop_front()});
        end
    end
    task automatic go(input int k, input logic [7:0] d);
        i_fsp_host.send(k, d, FSP_OP_PROG, 28'h0);
    endtask
    task automatic settle();
        for (int n = 0; n < 20 && status_o[0] !== 1'b0; n++) @(posedge clock_i) #1;
    endtask
    task automatic wst(input logic [7:0] d);
        go(0, 8'h00);
        go(2, d);
        settle();
    endtask
    task automatic run(input fsp_op_type t, input logic [27:0] a, input logic s);
        go(0, 8'h00);
        q.push_back(s);
        i_fsp_host.send(3, 8'h00, t, a);
        settle();
        chk({7'h0, status_o[1]}, 8'h00);
    endtask
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        void'($urandom(82));
        sect = $urandom % 4095 + 1;
        repeat (2) @(posedge clock_i);
        #1 reset_i = 1'b0;
        chk(status_o, 8'h00);
        chk(flag_status_o, 8'h80);
        i_fsp_host.send(3, 8'h00, FSP_OP_PROG, 28'h0);
        go(0, 8'h00);
        chk(status_o, 8'h02);
        go(1, 8'h00);
        chk(status_o, 8'h00);
        go(0, 8'h00);
        go(2, 8'h9f);
        chk(status_o, 8'h9f);
        chk(flag_status_o, 8'h00);
        settle();
        chk(status_o, 8'h9c);
        $display("test write done");
        go(0, 8'h00);
        q.push_back(1'b0);
        go(2, 8'h00);
        chk(status_o, 8'h9c);
        i_fsp_host.pin(1'b1);
        repeat (5) @(posedge clock_i);
        wst(8'h24);
        chk(status_o, 8'h24);
        $display("test lock done");
        run(FSP_OP_PROG, 28'h0, 1'b0);
        chk(flag_status_o, 8'h92);
        go(4, 8'h00);
        chk(flag_status_o, 8'h80);
        run(FSP_OP_PROG, 28'h0010000, 1'b1);
        run(FSP_OP_SECT_ERASE, {sect[11:0], 16'h0}, 1'b1);
        run(FSP_OP_DIE_ERASE, 28'h0, 1'b0);
        chk(flag_status_o, 8'ha2);
        go(4, 8'h00);
        wst(8'h50);
        run(FSP_OP_PROG, FSP_TOP_ADDR, 1'b0);
        run(FSP_OP_PROG, 28'h7ffffff, 1'b1);
        go(4, 8'h00);
        wst(8'h00);
        run(FSP_OP_DIE_ERASE, 28'h0, 1'b1);
        $display("test array done");
        repeat (2) @(posedge clock_i);
        chk({7'h0, q.size() == 0}, 8'h01);
        summarize();
    end
endmodule
